// ===== pin_mux_pkg.sv
// Shared pin map, carrier type and reset values for the pin output priority mux
package pin_mux_pkg;

  // One peripheral's drive request on a pin
  typedef struct packed {
    logic value;   // Level the peripheral wants on the pin
    logic enable;  // Peripheral has the pin configured as output
  } drive_t;

  // Pin count and most sources on any one pin
  localparam int NUM_PINS = 35;
  localparam int MAX_SOURCES = 3;

  // Pin positions on the pad side
  localparam int PIN_SPI0_SLAVE_OUT = 0;  // Shared with twowire0_data
  localparam int PIN_SPI0_CLOCK = 1;      // Shared with twowire0_clock
  localparam int PIN_SPI0_SELECT = 2;     // Shared with twowire1_clock
  localparam int PIN_SPI0_ENABLE = 3;     // Shared with twowire1_data
  localparam int PIN_AUDIO0_D5 = 4;       // Data lines 5..7, shared with spi_port1 lines
  localparam int PIN_AUDIO0_D8 = 7;       // Data lines 8..9, three-way shared
  localparam int PIN_AUDIO0_D10 = 9;      // Data lines 10..13, shared with audio1 3..0
  localparam int PIN_AUDIO0_D14 = 13;     // Data lines 14..15, shared with audio2 1..0
  localparam int PIN_RX_HIGH_CLOCK = 15;
  localparam int PIN_TX_HIGH_CLOCK = 16;
  localparam int PIN_MUTE_INTERRUPT = 17;
  localparam int PIN_HOSTDATA16 = 18;
  localparam int PIN_EXTMEM_BASE = 19;    // extmem_data[16+i] / host_address_in[i]
  localparam int EXTMEM_SHARED_BITS = 16;

  // Values held after reset
  localparam logic [NUM_PINS-1:0] PIN_OUT_RESET = 35'h0;
  localparam logic [NUM_PINS-1:0] PIN_OE_RESET = 35'h0;
  localparam logic [NUM_PINS-1:0] PIN_SAMPLE_RESET = 35'h0;

endpackage : pin_mux_pkg

// ===== pin_priority_select.sv
// Fixed-priority selection of one pin's drive among its sharing peripherals
`timescale 1ns/10ps
module pin_priority_select #(
  parameter int SOURCES = 3
) (
  input pin_mux_pkg::drive_t [SOURCES-1:0] requests, // Index 0 has first priority
  output pin_mux_pkg::drive_t grant                  // Resolved value and enable
);

  // Walk from lowest priority upward so the highest enabled source wins
  always_comb
  begin
    grant = '0;
    for (int i = SOURCES - 1; i >= 0; i--)
    begin
      if (requests[i].enable)
      begin
        grant.value = requests[i].value;
        grant.enable = 1'b1;
      end
    end
  end

endmodule : pin_priority_select

// ===== shared_pin_output_priority_mux.sv
// Output priority mux and input fan-out for device pins shared by several peripherals
`timescale 1ns/10ps
// Function
// - A shared pin drives whenever any sharer asks to, with the value of the top-priority asker.
// - The sampled pin level goes to every sharing peripheral at once, whoever drives it.
// - On the four serial port 0 / two-wire pins, serial port 0 wins over the two-wire signal.
// - Audio port 0 data lines 5 to 7 win over serial port 1 select, enable and clock.
// - Three-way pins go to audio 0 lines 8/9 first, audio 1 lines 5/4 next, serial port 1 last.
// - Audio 0 lines 10-13 beat audio 1 lines 3-0, and lines 14-15 beat audio 2 lines 1-0.
// - Audio 0 receive and transmit high clocks beat the audio 1 and audio 2 high clocks.
// - Audio 2 mute beats host interrupt, and host data bit 16 beats host halfword select.
// - External memory data bits 31 to 16 stop driving at the first clock edge that samples the host non-muxed mode bit at 1.
// - The host address bits sharing those pins are inputs only and never drive.
// - The memory interface parks its data bus by driving it, unless non-muxed mode gates it.
module shared_pin_output_priority_mux (
  input wire logic clk,                                        // 100 MHz system clock
  input wire logic rst,                                        // Synchronous reset, active high
  input pin_mux_pkg::drive_t [3:0] spi0Drive,                  // Slave out, clock, select, enable
  input pin_mux_pkg::drive_t [3:0] twowireDrive,               // tw0 data, tw0 clk, tw1 clk, tw1 data
  input pin_mux_pkg::drive_t [15:5] audio0Drive,               // audio0_data_lines 5..15
  input pin_mux_pkg::drive_t [5:0] audio1Drive,                // audio1_data_lines 0..5
  input pin_mux_pkg::drive_t [1:0] audio2Drive,                // audio2_data_lines 0..1
  input pin_mux_pkg::drive_t [4:0] spi1Drive,                  // Select, enable, clock, sout, sin
  input pin_mux_pkg::drive_t audio0RxHighClock,                // audio0_rx_high_clock
  input pin_mux_pkg::drive_t audio1RxHighClock,                // audio1_rx_high_clock
  input pin_mux_pkg::drive_t audio0TxHighClock,                // audio0_tx_high_clock
  input pin_mux_pkg::drive_t audio2TxHighClock,                // audio2_tx_high_clock
  input pin_mux_pkg::drive_t audio2MuteOut,                    // audio2_mute_out
  input pin_mux_pkg::drive_t hostInterruptOut,                 // host_interrupt_out
  input pin_mux_pkg::drive_t hostData16,                       // host_data bit 16
  input pin_mux_pkg::drive_t hostHalfwordSelect,               // host_halfword_select
  input pin_mux_pkg::drive_t [15:0] extmemDataUpper,           // extmem_data bits 31..16
  input wire logic hostNonmuxedModeBit,                        // Config bit, same clock domain
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] pinIn,          // Pad input levels (async)
  output logic [pin_mux_pkg::NUM_PINS-1:0] pinOut,             // Pad output levels
  output logic [pin_mux_pkg::NUM_PINS-1:0] pinOe,              // Pad output enables, high drives
  output logic [pin_mux_pkg::NUM_PINS-1:0] pinSample,          // Synchronised levels for all sharers
  output logic [15:0] hostAddressIn                            // host_address_in 15..0
);

  // Per-pin request lists, index 0 first priority
  pin_mux_pkg::drive_t [pin_mux_pkg::MAX_SOURCES-1:0] requests [pin_mux_pkg::NUM_PINS];
  pin_mux_pkg::drive_t grants [pin_mux_pkg::NUM_PINS];
  logic [pin_mux_pkg::NUM_PINS-1:0] next_pinOut;
  logic [pin_mux_pkg::NUM_PINS-1:0] next_pinOe;
  logic [pin_mux_pkg::NUM_PINS-1:0] pinMeta;

  // Build each pin's request list in priority order
  always_comb
  begin
    for (int p = 0; p < pin_mux_pkg::NUM_PINS; p++)
    begin
      requests[p] = '0;
    end
    // Serial port 0 first, two-wire second
    for (int k = 0; k < 4; k++)
    begin
      requests[pin_mux_pkg::PIN_SPI0_SLAVE_OUT + k][0] = spi0Drive[k];
      requests[pin_mux_pkg::PIN_SPI0_SLAVE_OUT + k][1] = twowireDrive[k];
    end
    // Audio 0 lines 5..7 over serial port 1 select, enable, clock
    for (int k = 0; k < 3; k++)
    begin
      requests[pin_mux_pkg::PIN_AUDIO0_D5 + k][0] = audio0Drive[5 + k];
      requests[pin_mux_pkg::PIN_AUDIO0_D5 + k][1] = spi1Drive[k];
    end
    // Three-way pins: audio 0, then audio 1 (lines 5 and 4), then serial port 1
    for (int k = 0; k < 2; k++)
    begin
      requests[pin_mux_pkg::PIN_AUDIO0_D8 + k][0] = audio0Drive[8 + k];
      requests[pin_mux_pkg::PIN_AUDIO0_D8 + k][1] = audio1Drive[5 - k];
      requests[pin_mux_pkg::PIN_AUDIO0_D8 + k][2] = spi1Drive[3 + k];
    end
    // Audio 0 lines 10..13 over audio 1 lines 3..0
    for (int k = 0; k < 4; k++)
    begin
      requests[pin_mux_pkg::PIN_AUDIO0_D10 + k][0] = audio0Drive[10 + k];
      requests[pin_mux_pkg::PIN_AUDIO0_D10 + k][1] = audio1Drive[3 - k];
    end
    // Audio 0 lines 14..15 over audio 2 lines 1..0
    for (int k = 0; k < 2; k++)
    begin
      requests[pin_mux_pkg::PIN_AUDIO0_D14 + k][0] = audio0Drive[14 + k];
      requests[pin_mux_pkg::PIN_AUDIO0_D14 + k][1] = audio2Drive[1 - k];
    end
    // High clocks: audio 0 wins on both
    requests[pin_mux_pkg::PIN_RX_HIGH_CLOCK][0] = audio0RxHighClock;
    requests[pin_mux_pkg::PIN_RX_HIGH_CLOCK][1] = audio1RxHighClock;
    requests[pin_mux_pkg::PIN_TX_HIGH_CLOCK][0] = audio0TxHighClock;
    requests[pin_mux_pkg::PIN_TX_HIGH_CLOCK][1] = audio2TxHighClock;
    // Mute over host interrupt, host data 16 over halfword select
    requests[pin_mux_pkg::PIN_MUTE_INTERRUPT][0] = audio2MuteOut;
    requests[pin_mux_pkg::PIN_MUTE_INTERRUPT][1] = hostInterruptOut;
    requests[pin_mux_pkg::PIN_HOSTDATA16][0] = hostData16;
    requests[pin_mux_pkg::PIN_HOSTDATA16][1] = hostHalfwordSelect;
    // Memory data upper half; parking drive passes through unless non-muxed mode gates it
    for (int k = 0; k < pin_mux_pkg::EXTMEM_SHARED_BITS; k++)
    begin
      requests[pin_mux_pkg::PIN_EXTMEM_BASE + k][0].value = extmemDataUpper[k].value;
      requests[pin_mux_pkg::PIN_EXTMEM_BASE + k][0].enable =
        extmemDataUpper[k].enable & ~hostNonmuxedModeBit;
      // Host address slot stays empty: it never drives
      requests[pin_mux_pkg::PIN_EXTMEM_BASE + k][1] = '0;
    end
  end

  // One priority selector per pin
  for (genvar g = 0; g < pin_mux_pkg::NUM_PINS; g++)
  begin : gen_pin
    pin_priority_select #(
      .SOURCES(pin_mux_pkg::MAX_SOURCES)
    ) u_select (
      .requests(requests[g]),
      .grant(grants[g])
    );
  end

  // Flatten grants into next pad values
  always_comb
  begin
    for (int p = 0; p < pin_mux_pkg::NUM_PINS; p++)
    begin
      next_pinOut[p] = grants[p].value;
      next_pinOe[p] = grants[p].enable;
    end
  end

  // Registered pad drive so the pad sees clean flop outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinOut <= pin_mux_pkg::PIN_OUT_RESET;
      pinOe <= pin_mux_pkg::PIN_OE_RESET;
    end
    else
    begin
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
    end
  end

  // Two-flop synchroniser; the second stage feeds every sharer alike
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinMeta <= pin_mux_pkg::PIN_SAMPLE_RESET;
      pinSample <= pin_mux_pkg::PIN_SAMPLE_RESET;
    end
    else
    begin
      pinMeta <= pinIn;
      pinSample <= pinMeta;
    end
  end

  // Host address taps the second stage, so no path reads an unresolved first-stage level
  assign hostAddressIn =
    pinSample[pin_mux_pkg::PIN_EXTMEM_BASE +: pin_mux_pkg::EXTMEM_SHARED_BITS];

endmodule : shared_pin_output_priority_mux

// ===== pin_mux_assertions.sv
// Concurrent checks on the shared pin output priority mux
`timescale 1ns/10ps
module pin_mux_assertions (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input pin_mux_pkg::drive_t [3:0] spi0Drive, // Serial 0
  input pin_mux_pkg::drive_t [3:0] twowireDrive, // Two-wire
  input pin_mux_pkg::drive_t [15:5] audio0Drive, // Audio 0
  input pin_mux_pkg::drive_t [5:0] audio1Drive, // Audio 1
  input pin_mux_pkg::drive_t [15:0] extmemDataUpper, // Memory data
  input wire logic hostNonmuxedModeBit, // Mode bit
  input wire logic [34:0] pinIn, // Pad in
  input logic [34:0] pinOut, // Pad out
  input logic [34:0] pinOe, // Pad enable
  input logic [34:0] pinSample, // Samples
  input logic [15:0] hostAddressIn // Host address
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Drive enables and winners one cycle after the requests
  property p_oeAny; 1'b1 |=> pinOe[0] == $past(spi0Drive[0].enable | twowireDrive[0].enable);
  endproperty
  a_oeAny: assert property (p_oeAny) else $error("pin 0 enable wrong");
  property p_spi0Wins; spi0Drive[1].enable |=> pinOut[1] == $past(spi0Drive[1].value); endproperty
  a_spi0Wins: assert property (p_spi0Wins) else $error("pin 1 value wrong");
  property p_audioWins; audio0Drive[5].enable |=> pinOut[4] == $past(audio0Drive[5].value);
  endproperty
  a_audioWins: assert property (p_audioWins) else $error("pin 4 value wrong");
  property p_second; !audio0Drive[8].enable && audio1Drive[5].enable
    |=> pinOut[7] == $past(audio1Drive[5].value); endproperty
  a_second: assert property (p_second) else $error("pin 7 value wrong");
  // Memory data gating and parking
  property p_gated; hostNonmuxedModeBit |=> pinOe[34:19] == 16'h0; endproperty
  a_gated: assert property (p_gated) else $error("memory pins driven");
  property p_park; !hostNonmuxedModeBit && extmemDataUpper[0].enable
    |=> pinOe[19] && pinOut[19] == $past(extmemDataUpper[0].value); endproperty
  a_park: assert property (p_park) else $error("pin 19 not parked");
  // Input fan-out
  property p_sample; $stable(pinIn) [*3] |-> pinSample == pinIn; endproperty
  a_sample: assert property (p_sample) else $error("sample wrong");
  property p_addr; $stable(pinIn[34:19]) [*3] |-> hostAddressIn == pinIn[34:19]; endproperty
  a_addr: assert property (p_addr) else $error("host address wrong");
  c_both: cover property (spi0Drive[1].enable && twowireDrive[1].enable);
  c_nonmux: cover property (hostNonmuxedModeBit && extmemDataUpper[0].enable);
  c_three: cover property (audio1Drive[5].enable && !audio0Drive[8].enable);
endmodule : pin_mux_assertions
bind shared_pin_output_priority_mux pin_mux_assertions pin_mux_assertions_inst (.clk, .rst,
  .spi0Drive, .twowireDrive, .audio0Drive, .audio1Drive, .extmemDataUpper, .hostNonmuxedModeBit,
  .pinIn, .pinOut, .pinOe, .pinSample, .hostAddressIn);

// ===== pad_ring_model.sv
// Pad ring model resolving each shared pin between device and board
`timescale 1ns/10ps
module pad_ring_model (
  input wire logic [34:0] pinOut, // Device levels
  input wire logic [34:0] pinOe, // Device enables
  input wire logic [34:0] boardLevel, // Board levels
  output logic [34:0] pinIn // Pad levels
);
  // Driven pins show the device, the rest the board
  assign pinIn = (pinOe & pinOut) | (~pinOe & boardLevel);
endmodule : pad_ring_model

// ===== shared_pin_output_priority_mux_tb.sv
// Self-checking bench for the shared pin output priority mux
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module shared_pin_output_priority_mux_tb;
  typedef struct packed {logic [5:0] req; logic [1:0] exp;} row_t;
  logic clk = 0;
  logic rst = 1;
  pin_mux_pkg::drive_t [3:0] spi0Drive = '0, twowireDrive = '0;
  pin_mux_pkg::drive_t [15:5] audio0Drive = '0;
  pin_mux_pkg::drive_t [5:0] audio1Drive = '0;
  pin_mux_pkg::drive_t [1:0] audio2Drive = '0;
  pin_mux_pkg::drive_t [4:0] spi1Drive = '0;
  pin_mux_pkg::drive_t audio0RxHighClock = '0, audio1RxHighClock = '0, audio0TxHighClock = '0;
  pin_mux_pkg::drive_t audio2TxHighClock = '0, audio2MuteOut = '0, hostInterruptOut = '0;
  pin_mux_pkg::drive_t hostData16 = '0, hostHalfwordSelect = '0;
  pin_mux_pkg::drive_t [15:0] extmemDataUpper = '0;
  logic hostNonmuxedModeBit = 0;
  logic [34:0] pinIn, pinOut, pinOe, pinSample;
  logic [34:0] boardLevel = 35'h2a5a5c3c3;
  logic [15:0] hostAddressIn;
  logic [15:0] pattern = 16'h5a3c;
  int miscompares = 0;
  int checks = 0;
  row_t rows [6] = '{'{6'h34, 2'h3}, '{6'h1c, 2'h1}, '{6'h2c, 2'h3}, '{6'h0c, 2'h3},
    '{6'h07, 2'h1}, '{6'h13, 2'h1}};
  int pins [19] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18};
  shared_pin_output_priority_mux shared_pin_output_priority_mux_inst (.clk, .rst, .spi0Drive,
    .twowireDrive, .audio0Drive, .audio1Drive, .audio2Drive, .spi1Drive, .audio0RxHighClock,
    .audio1RxHighClock, .audio0TxHighClock, .audio2TxHighClock, .audio2MuteOut,
    .hostInterruptOut, .hostData16, .hostHalfwordSelect, .extmemDataUpper,
    .hostNonmuxedModeBit, .pinIn, .pinOut, .pinOe, .pinSample, .hostAddressIn);
  pad_ring_model pad_ring_model_inst (.pinOut, .pinOe, .boardLevel, .pinIn);
  // Clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Puts one row of requests, first priority first, on a pin's sharers
  task drv(input int p, input logic [5:0] r);
    @(posedge clk);
    case (p)
      0, 1, 2, 3: {spi0Drive[p], twowireDrive[p]} <= r[5:2];
      4, 5, 6: {audio0Drive[p + 1], spi1Drive[p - 4]} <= r[5:2];
      7, 8: {audio0Drive[p + 1], audio1Drive[12 - p], spi1Drive[p - 4]} <= r;
      9, 10, 11, 12: {audio0Drive[p + 1], audio1Drive[12 - p]} <= r[5:2];
      13, 14: {audio0Drive[p + 1], audio2Drive[14 - p]} <= r[5:2];
      15: {audio0RxHighClock, audio1RxHighClock} <= r[5:2];
      16: {audio0TxHighClock, audio2TxHighClock} <= r[5:2];
      17: {audio2MuteOut, hostInterruptOut} <= r[5:2];
      default: {hostData16, hostHalfwordSelect} <= r[5:2];
    endcase
  endtask : drv
  task summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  // Watchdog
  initial
  begin
    repeat (2000) @(posedge clk);
    miscompares++;
    summarize();
  end
  // Tests
  initial
  begin
    repeat (15) @(posedge clk);
    #1 `CHK("reset oe", pin_mux_pkg::PIN_OE_RESET, pinOe)
    `CHK("reset out", pin_mux_pkg::PIN_OUT_RESET, pinOut)
    `CHK("reset sample", pin_mux_pkg::PIN_SAMPLE_RESET, pinSample)
    `CHK("reset host address", 16'h0, hostAddressIn)
    @(posedge clk) rst <= 0;
    $display("reset test done");
    foreach (pins[i])
    begin
      foreach (rows[j])
      begin
        drv(pins[i], rows[j].req);
        @(posedge clk) #1 `CHK("pin drive", rows[j].exp, {pinOut[pins[i]], pinOe[pins[i]]})
        drv(pins[i], 6'h0);
      end
    end
    drv(7, 6'h03);
    @(posedge clk) #1 `CHK("third source", 2'h3, {pinOut[7], pinOe[7]})
    drv(7, 6'h0);
    drv(8, 6'h01);
    @(posedge clk) #1 `CHK("third source", 2'h1, {pinOut[8], pinOe[8]})
    drv(8, 6'h0);
    $display("priority tests done");
    // Mode bit goes up while the memory drivers still stand as inputs
    @(posedge clk) hostNonmuxedModeBit <= 1;
    repeat (3) @(posedge clk);
    #1 `CHK("host address idle", boardLevel[34:19], hostAddressIn)
    @(posedge clk);
    foreach (extmemDataUpper[k]) extmemDataUpper[k] <= {pattern[k], 1'b1};
    @(posedge clk) #1 `CHK("gated oe", 16'h0, pinOe[34:19])
    repeat (3) @(posedge clk);
    #1 `CHK("host address", boardLevel[34:19], hostAddressIn)
    @(posedge clk) hostNonmuxedModeBit <= 0;
    @(posedge clk) #1 `CHK("parked oe", 16'hffff, pinOe[34:19])
    `CHK("parked out", pattern, pinOut[34:19])
    repeat (3) @(posedge clk);
    #1 `CHK("fanout", {pattern, boardLevel[18:0]}, pinSample)
    $display("sharing tests done");
    // Reset in mid-run while the memory bus is parked
    @(posedge clk) rst <= 1;
    @(posedge clk) #1 `CHK("midrun reset oe", pin_mux_pkg::PIN_OE_RESET, pinOe)
    `CHK("midrun reset out", pin_mux_pkg::PIN_OUT_RESET, pinOut)
    `CHK("midrun reset sample", pin_mux_pkg::PIN_SAMPLE_RESET, pinSample)
    @(posedge clk) rst <= 0;
    @(posedge clk) #1 `CHK("release oe", {16'hffff, 19'h0}, pinOe)
    $display("midrun reset test done");
    summarize();
  end
endmodule : shared_pin_output_priority_mux_tb
